// >>> rtl/smc_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Six modes: init, normal (main), stop, sleep, restart, fail-safe.
// - Power-up enters init mode; soft reset command does too, except from sleep or fail-safe.
// - Stop mode keeps the main regulator output on.
// - Sleep mode switches the main regulator output off.
// - Sleep wake or failure, or fail-safe wake, enters restart with controller reset.
// - Restart leaves to normal after reset delay once failure is gone.
// - Critical failures enter fail-safe with main regulator output off.
// - Fail-safe held until a wake arrives and no overtemperature remains.
// - Development mode keeps all modes reachable; watchdog counter frozen.
// - Mode requests and soft reset pass over a 16-bit SPI link; diagnosis uses output ports.
// - Host writes the mode field to request modes; device acts on it.
// - Mode field cleared on every pass through restart.
// - Any SPI command in init other than a soft reset, legal or not, moves to normal.
// - Wake events during init are dropped unrecorded.
// - Stop to sleep request flags SPI error and enters restart.
// - Sleep wake returns to normal via restart and reports wake source.
module smc_mode_ctrl
    import smc_pkg::*;
#(
    parameter int RESET_DELAY_CYC = SMC_RESET_DELAY_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic spi_clk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    input wire logic wake_can_i,
    input wire logic wake_lin_i,
    input wire logic high_voltage_wake_input_i,
    input wire logic test_pin_i,
    input wire logic wd_fail_i,
    input wire logic main_uv_i,
    input wire logic thermal_shutdown_level2_i,
    input wire logic main_short_i,
    input wire logic overtemp_i,
    input wire logic spi_err_clr_i,
    output logic main_regulator_output_o,
    output logic mcu_reset_n_o,
    output logic [2:0] op_mode_o,
    output logic [2:0] mode_field_o,
    output logic dev_mode_o,
    output logic wd_run_o,
    output logic spi_command_error_flag_o,
    output logic [2:0] wake_source_o
);
    localparam int DLY_W = $clog2(RESET_DELAY_CYC + 1);

    smc_mode_t mode;
    smc_mode_t next_mode;
    logic frame_valid;
    logic [SMC_FRAME_BITS-1:0] frame;
    logic [9:0] pin_s1;
    logic [9:0] pin_s2;
    logic w_can, w_lin, w_hv, test_lvl;
    logic f_wd, f_uv, f_tsd, f_short, f_ot;
    logic any_wake;
    logic fail_restart;
    logic fail_crit;
    logic is_write;
    logic mode_wr;
    logic soft_rst;
    logic [2:0] req;
    logic [DLY_W-1:0] dly_cnt;
    logic stop_to_sleep;

    // ------------------------------------------------------------
    // Link receiver
    // ------------------------------------------------------------
    // 16-bit frame link
    smc_spi_rx #(
        .FRAME_BITS(SMC_FRAME_BITS)
    ) u_rx (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .spi_clk_i(spi_clk_i),
        .spi_cs_n_i(spi_cs_n_i),
        .spi_mosi_i(spi_mosi_i),
        .frame_valid_o(frame_valid),
        .frame_o(frame)
    );

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        // Test pin idles high; a low reset value would fake the strap
        if (rst_i) begin
            pin_s1 <= 10'h040;
            pin_s2 <= 10'h040;
        end else begin
            pin_s1 <= {wake_can_i, wake_lin_i, high_voltage_wake_input_i,
                       test_pin_i, wd_fail_i, main_uv_i,
                       thermal_shutdown_level2_i, main_short_i,
                       overtemp_i, spi_err_clr_i};
            pin_s2 <= pin_s1;
        end
    end

    logic err_clr;
    assign {w_can, w_lin, w_hv, test_lvl, f_wd, f_uv, f_tsd, f_short,
            f_ot, err_clr} = pin_s2;
    assign any_wake = w_can | w_lin | w_hv;
    // Watchdog failures are ignored while in development mode
    assign fail_restart = (f_wd & ~dev_mode_o) | f_uv;
    assign fail_crit = f_tsd | f_short;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    assign is_write = frame[SMC_WR_BIT];
    assign req = frame[SMC_MODE_MSB:SMC_MODE_LSB];
    assign mode_wr = frame_valid & is_write
                     & (frame[6:0] == SMC_MODE_REG_IDX);
    assign soft_rst = (mode_wr & (req == SMC_REQ_RESET))
                      | (frame_valid & is_write
                         & (frame[6:0] == SMC_SOFT_RST_IDX));
    assign stop_to_sleep = (mode == SMC_STOP) & mode_wr
                           & (req == SMC_REQ_SLEEP);

    // ------------------------------------------------------------
    // Mode transitions
    // ------------------------------------------------------------
    // frame-based, clocked evaluation
    always_comb begin
        next_mode = mode;
        case (mode)
            SMC_INIT: begin
                if (frame_valid) begin
                    next_mode = SMC_NORMAL;
                end
            end
            SMC_NORMAL: begin
                if (mode_wr && req == SMC_REQ_SLEEP) begin
                    next_mode = SMC_SLEEP;
                end else if (mode_wr && req == SMC_REQ_STOP) begin
                    next_mode = SMC_STOP;
                end
            end
            SMC_STOP: begin
                if (stop_to_sleep) begin
                    next_mode = SMC_RESTART;
                end else if (mode_wr && req == SMC_REQ_NORMAL) begin
                    next_mode = SMC_NORMAL;
                end
            end
            SMC_SLEEP: begin
                if (any_wake) begin
                    next_mode = SMC_RESTART;
                end
            end
            SMC_RESTART: begin
                if (!fail_restart
                    && dly_cnt == DLY_W'(RESET_DELAY_CYC - 1)) begin
                    next_mode = SMC_NORMAL;
                end
            end
            SMC_FAILSAFE: begin
                if (any_wake && !f_ot) begin
                    next_mode = SMC_RESTART;
                end
            end
            default: begin
                next_mode = SMC_INIT;
            end
        endcase
        if (mode != SMC_FAILSAFE && mode != SMC_INIT && fail_restart) begin
            next_mode = SMC_RESTART;
        end
        if (fail_crit) begin
            next_mode = SMC_FAILSAFE;
        end
        if (soft_rst && mode != SMC_SLEEP && mode != SMC_FAILSAFE) begin
            next_mode = SMC_INIT;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mode <= SMC_INIT;
        end else begin
            mode <= next_mode;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            dly_cnt <= '0;
        end else if (mode == SMC_RESTART && !fail_restart) begin
            if (dly_cnt != DLY_W'(RESET_DELAY_CYC - 1)) begin
                dly_cnt <= dly_cnt + 1'b1;
            end
        end else begin
            dly_cnt <= '0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // regulator per mode
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            main_regulator_output_o <= 1'b1;
        end else begin
            main_regulator_output_o <= (next_mode != SMC_SLEEP)
                                       && (next_mode != SMC_FAILSAFE);
        end
    end

    // reset held through restart and init
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mcu_reset_n_o <= 1'b0;
        end else begin
            mcu_reset_n_o <= (next_mode != SMC_RESTART)
                             && (next_mode != SMC_INIT)
                             && (next_mode != SMC_SLEEP)
                             && (next_mode != SMC_FAILSAFE);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            op_mode_o <= 3'h0;
        end else begin
            op_mode_o <= 3'(next_mode);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mode_field_o <= SMC_MODE_RST_VAL;
        end else if (next_mode == SMC_RESTART || next_mode == SMC_INIT) begin
            mode_field_o <= SMC_MODE_RST_VAL;
        end else if (mode_wr && next_mode != mode) begin
            mode_field_o <= req;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            dev_mode_o <= 1'b0;
        end else if (mode == SMC_INIT) begin
            dev_mode_o <= ~test_lvl;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wd_run_o <= 1'b0;
        end else begin
            wd_run_o <= ~dev_mode_o && (mode == SMC_NORMAL
                                        || mode == SMC_STOP);
        end
    end

    // error flag, set wins over clear
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            spi_command_error_flag_o <= 1'b0;
        end else if (stop_to_sleep) begin
            spi_command_error_flag_o <= 1'b1;
        end else if (err_clr) begin
            spi_command_error_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wake_source_o <= 3'h0;
        end else if ((mode == SMC_SLEEP || mode == SMC_FAILSAFE)
                     && any_wake) begin
            wake_source_o <= wake_source_o | {w_can, w_lin, w_hv};
        end else if (mode == SMC_INIT) begin
            wake_source_o <= 3'h0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_in_sleep_wake;
        mode == SMC_SLEEP && any_wake && !fail_crit && !soft_rst;
    endsequence

    property p_sleep_wake;
        @(posedge clk_sys_i) disable iff (rst_i)
        s_in_sleep_wake |=> mode == SMC_RESTART ##0 !mcu_reset_n_o;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake)
        else $error("sleep wake did not enter restart");

    property p_sleep_reg;
        @(posedge clk_sys_i) disable iff (rst_i)
        mode == SMC_SLEEP |-> !main_regulator_output_o;
    endproperty
    a_sleep_reg: assert property (p_sleep_reg)
        else $error("regulator on in sleep");

    property p_stop_reg;
        @(posedge clk_sys_i) disable iff (rst_i)
        mode == SMC_STOP |-> main_regulator_output_o;
    endproperty
    a_stop_reg: assert property (p_stop_reg)
        else $error("regulator off in stop");

    property p_crit;
        @(posedge clk_sys_i) disable iff (rst_i)
        fail_crit && !soft_rst |=> mode == SMC_FAILSAFE
                                   && !main_regulator_output_o;
    endproperty
    a_crit: assert property (p_crit)
        else $error("critical failure missed fail-safe");

    property p_fs_hold;
        @(posedge clk_sys_i) disable iff (rst_i)
        mode == SMC_FAILSAFE && (!any_wake || f_ot) |=> mode == SMC_FAILSAFE;
    endproperty
    a_fs_hold: assert property (p_fs_hold)
        else $error("fail-safe left without wake");

    property p_init_any;
        @(posedge clk_sys_i) disable iff (rst_i)
        mode == SMC_INIT && frame_valid && !fail_crit && !soft_rst
        |=> mode == SMC_NORMAL;
    endproperty
    a_init_any: assert property (p_init_any)
        else $error("frame in init did not reach normal");

    property p_stop_sleep;
        @(posedge clk_sys_i) disable iff (rst_i)
        stop_to_sleep && !fail_crit
        |=> spi_command_error_flag_o && mode == SMC_RESTART;
    endproperty
    a_stop_sleep: assert property (p_stop_sleep)
        else $error("stop to sleep not refused");

    property p_field_clr;
        @(posedge clk_sys_i) disable iff (rst_i)
        mode == SMC_RESTART |-> mode_field_o == SMC_MODE_RST_VAL;
    endproperty
    a_field_clr: assert property (p_field_clr)
        else $error("mode field kept in restart");

    property p_dev_wd;
        @(posedge clk_sys_i) disable iff (rst_i)
        dev_mode_o ##1 dev_mode_o |-> !wd_run_o;
    endproperty
    a_dev_wd: assert property (p_dev_wd)
        else $error("watchdog runs in development mode");
endmodule // smc_mode_ctrl
`default_nettype wire

// >>> rtl/smc_pkg.sv
package smc_pkg;
    // ------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SMC_INIT,
        SMC_NORMAL,
        SMC_STOP,
        SMC_SLEEP,
        SMC_RESTART,
        SMC_FAILSAFE
    } smc_mode_t;

    // ------------------------------------------------------------
    // SPI frame layout
    // ------------------------------------------------------------
    localparam int SMC_FRAME_BITS = 16;
    localparam int SMC_CNT_W = 5;
    // Bit 7 set: write access; bits 6:0 register index
    localparam int SMC_WR_BIT = 7;
    localparam logic [6:0] SMC_MODE_REG_IDX = 7'h01;
    localparam logic [6:0] SMC_SOFT_RST_IDX = 7'h02;
    // Mode field in data byte, bits 15:13 of the frame
    localparam int SMC_MODE_MSB = 15;
    localparam int SMC_MODE_LSB = 13;
    localparam logic [2:0] SMC_REQ_NORMAL = 3'h0;
    localparam logic [2:0] SMC_REQ_SLEEP = 3'h1;
    localparam logic [2:0] SMC_REQ_STOP = 3'h2;
    localparam logic [2:0] SMC_REQ_RESET = 3'h3;
    localparam logic [2:0] SMC_MODE_RST_VAL = 3'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SMC_CLK_MHZ = 100;
    localparam int SMC_RESET_DELAY_US = 10;
    localparam int SMC_RESET_DELAY_CYC = SMC_RESET_DELAY_US * SMC_CLK_MHZ;
endpackage

// >>> rtl/smc_spi_rx.sv
`timescale 1ns/1ps
`default_nettype none
// Receives one 16-bit frame on the link clock and hands it over
// to the system clock with a toggle crossing.
module smc_spi_rx
    import smc_pkg::*;
#(
    parameter int FRAME_BITS = SMC_FRAME_BITS
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic spi_clk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic frame_valid_o,
    output logic [FRAME_BITS-1:0] frame_o
);
    logic [FRAME_BITS-1:0] shift;
    logic [SMC_CNT_W-1:0] bit_cnt;
    logic [FRAME_BITS-1:0] hold;
    logic link_tog;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;

    // ------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------
    // Chip select clears the count asynchronously since the link
    // clock stops between frames.
    always_ff @(posedge spi_clk_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            bit_cnt <= '0;
        end else begin
            bit_cnt <= bit_cnt + 1'b1;
        end
    end

    always_ff @(posedge spi_clk_i) begin
        shift <= {shift[FRAME_BITS-2:0], spi_mosi_i};
    end

    always_ff @(posedge spi_clk_i) begin
        if (bit_cnt == SMC_CNT_W'(FRAME_BITS - 1)) begin
            hold <= {shift[FRAME_BITS-2:0], spi_mosi_i};
        end
    end

    // Reset meets an idle link clock; toggle starts level with the
    // system-side flops, so no false frame follows a reset
    always_ff @(posedge spi_clk_i or posedge rst_i) begin
        if (rst_i) begin
            link_tog <= 1'b0;
        end else if (bit_cnt == SMC_CNT_W'(FRAME_BITS - 1)) begin
            link_tog <= ~link_tog;
        end
    end

    // ------------------------------------------------------------
    // System domain
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
            frame_valid_o <= 1'b0;
            frame_o <= '0;
        end else begin
            tog_s1 <= link_tog;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
            frame_valid_o <= tog_s2 ^ tog_s3;
            // Hold is stable for at least two system cycles by now
            if (tog_s2 ^ tog_s3) begin
                frame_o <= hold;
            end
        end
    end

endmodule // smc_spi_rx
`default_nettype wire

// >>> sim/smc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module smc_host_model (
    output logic spi_clk_o,
    output logic spi_cs_n_o,
    output logic spi_mosi_o
);
    // ------------------------------------------------------------
    // Controller side of the link
    // ------------------------------------------------------------
    initial begin
        spi_clk_o = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = 1'b0;
    end

    // msb first frames
    // Clock stands low between frames; data shows junk when idle
    task automatic send(input logic [15:0] f, input int nb);
        int i;
        begin
            spi_cs_n_o = 1'b0;
            for (i = 15; i > 15 - nb; i--) begin
                spi_mosi_o = f[i];
                #6;
                spi_clk_o = 1'b1;
                #6;
                spi_clk_o = 1'b0;
            end
            #6;
            spi_cs_n_o = 1'b1;
            spi_mosi_o = ~spi_mosi_o;
        end
    endtask
endmodule // smc_host_model
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import smc_pkg::*;
;
    localparam int RD = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wk_can = 1'b0;
    logic wk_lin = 1'b0;
    logic wk_hv = 1'b0;
    logic tpin = 1'b1;
    logic wdf = 1'b0;
    logic uv = 1'b0;
    logic tsd = 1'b0;
    logic shrt = 1'b0;
    logic otmp = 1'b0;
    logic eclr = 1'b0;
    wire spi_clk, cs_n, mosi, reg_en, rst_n, dev, wdrun, eflag;
    wire [2:0] op, mfield, wsrc;
    int err_total = 0;
    int n_checks = 0;

    initial begin
        forever #5 clk = ~clk;
    end

    smc_host_model smc_host_model_inst (
        .spi_clk_o(spi_clk), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi));

    smc_mode_ctrl #(.RESET_DELAY_CYC(RD)) smc_mode_ctrl_inst (
        .clk_sys_i(clk), .rst_i(rst), .spi_clk_i(spi_clk),
        .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .wake_can_i(wk_can),
        .wake_lin_i(wk_lin), .high_voltage_wake_input_i(wk_hv),
        .test_pin_i(tpin), .wd_fail_i(wdf), .main_uv_i(uv),
        .thermal_shutdown_level2_i(tsd), .main_short_i(shrt),
        .overtemp_i(otmp), .spi_err_clr_i(eclr),
        .main_regulator_output_o(reg_en), .mcu_reset_n_o(rst_n),
        .op_mode_o(op), .mode_field_o(mfield), .dev_mode_o(dev),
        .wd_run_o(wdrun), .spi_command_error_flag_o(eflag),
        .wake_source_o(wsrc));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [2:0] e,
                       input logic [2:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Bounded wait, then judge the mode
    task automatic go(input logic [2:0] m, input int lim);
        int i;
        i = 0;
        while (op !== m && i < lim) begin
            cyc(1);
            i++;
        end
        chk("op_mode", m, op);
    endtask

    task automatic frame(input logic [15:0] f);
        smc_host_model_inst.send(f, 16);
        cyc(8);
    endtask

    task automatic pulse(ref logic s, input int n);
        s = 1'b1;
        cyc(n);
        s = 1'b0;
    endtask

    function automatic logic [15:0] wr(input logic [2:0] m);
        return {m, 5'h00, 1'b1, SMC_MODE_REG_IDX};
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_init();
        chk("op_mode", SMC_INIT, op);
        chk1("reg_en", 1'b1, reg_en);
        chk1("mcu_rst_n", 1'b0, rst_n);
        pulse(wk_can, 5);
        cyc(5);
        chk("op_mode", SMC_INIT, op);
        chk("wake_src", 3'h0, wsrc);
        frame(16'h007f);
        go(SMC_NORMAL, 10);
        chk1("mcu_rst_n", 1'b1, rst_n);
        chk1("dev_mode", 1'b0, dev);
        chk1("wd_run", 1'b1, wdrun);
    endtask

    task automatic t_stop();
        frame(wr(SMC_REQ_STOP));
        go(SMC_STOP, 10);
        chk1("reg_en", 1'b1, reg_en);
        chk("mode_field", SMC_REQ_STOP, mfield);
        frame(wr(SMC_REQ_SLEEP));
        go(SMC_RESTART, 10);
        chk1("err_flag", 1'b1, eflag);
        chk("mode_field", 3'h0, mfield);
        chk1("mcu_rst_n", 1'b0, rst_n);
        go(SMC_NORMAL, RD + 10);
        pulse(eclr, 3);
        cyc(4);
        chk1("err_flag", 1'b0, eflag);
        smc_host_model_inst.send(wr(SMC_REQ_STOP), 8);
        cyc(20);
        chk("op_mode", SMC_NORMAL, op);
    endtask

    task automatic t_sleep();
        frame(wr(SMC_REQ_SLEEP));
        go(SMC_SLEEP, 10);
        chk1("reg_en", 1'b0, reg_en);
        pulse(wk_lin, 5);
        go(SMC_RESTART, 10);
        go(SMC_NORMAL, RD + 10);
        chk("wake_src", 3'b010, wsrc);
        chk1("reg_en", 1'b1, reg_en);
    endtask

    task automatic t_fail();
        int k;
        for (k = 0; k < 2; k++) begin
            if (k == 0) pulse(tsd, 5);
            else pulse(shrt, 5);
            go(SMC_FAILSAFE, 10);
            chk1("reg_en", 1'b0, reg_en);
            otmp = 1'b1;
            pulse(wk_can, 5);
            cyc(10);
            chk("op_mode", SMC_FAILSAFE, op);
            otmp = 1'b0;
            cyc(3);
            pulse(wk_hv, 5);
            go(SMC_RESTART, 10);
            go(SMC_NORMAL, RD + 10);
        end
    endtask

    task automatic t_restart();
        int k;
        for (k = 0; k < 2; k++) begin
            if (k == 0) wdf = 1'b1;
            else uv = 1'b1;
            go(SMC_RESTART, 10);
            chk1("mcu_rst_n", 1'b0, rst_n);
            cyc(40);
            chk("op_mode", SMC_RESTART, op);
            wdf = 1'b0;
            uv = 1'b0;
            cyc(RD / 2);
            chk("op_mode", SMC_RESTART, op);
            go(SMC_NORMAL, RD + 10);
            chk("mode_field", 3'h0, mfield);
        end
    endtask

    task automatic t_dev();
        frame(wr(SMC_REQ_RESET));
        go(SMC_INIT, 10);
        chk("wake_src", 3'h0, wsrc);
        tpin = 1'b0;
        cyc(5);
        chk1("dev_mode", 1'b1, dev);
        chk1("wd_run", 1'b0, wdrun);
        frame(16'h007f);
        go(SMC_NORMAL, 10);
        tpin = 1'b1;
        pulse(wdf, 20);
        cyc(5);
        chk("op_mode", SMC_NORMAL, op);
        chk1("wd_run", 1'b0, wdrun);
        frame(wr(SMC_REQ_STOP));
        go(SMC_STOP, 10);
        frame(wr(SMC_REQ_NORMAL));
        go(SMC_NORMAL, 10);
        frame({8'h00, 1'b1, SMC_SOFT_RST_IDX});
        go(SMC_INIT, 10);
    endtask

    // ------------------------------------------------------------
    // Sequence and verdict
    // ------------------------------------------------------------
    task automatic final_report();
        if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        cyc(2);
        t_init();
        t_stop();
        t_sleep();
        t_fail();
        t_restart();
        t_dev();
        final_report();
    end

    // Whole run is a few microseconds; this is ample
    initial begin
        #100000;
        err_total++;
        final_report();
    end
endmodule // tb
`default_nettype wire
